/* File: hw/foc_cfg_consts.vh */
// Constants for the startup and closed-loop configuration decoder
`ifndef FOC_CFG_CONSTS_VH
`define FOC_CFG_CONSTS_VH

// Register bus
`define CFG_ADDR_W 8
`define CFG_DATA_W 32
`define STARTUP_CONFIG_TWO_ADDR 8'h44
`define CLOSED_LOOP_CONFIG_ADDR 8'h48
`define LOOP_STATUS_ADDR 8'h4C
`define STARTUP_CONFIG_TWO_RST 32'h00000000
`define CLOSED_LOOP_CONFIG_RST 32'h00000000
`define CFG_READ_ZERO 32'h00000000

// startup_config_two fields
`define SCS_MSB 7
`define SCS_LSB 4
`define ICS_SEL_BIT 3
`define TER_MSB 2
`define TER_LSB 0

// closed_loop_config fields
`define CL_RSVD_MSB 31
`define CL_RSVD_LSB 30
`define CL_MODE_MSB 29
`define CL_MODE_LSB 28
`define CL_FAST_BIT 27
`define CL_ILIM_MSB 26
`define CL_ILIM_LSB 22
`define CL_STOP_MSB 21
`define CL_STOP_LSB 20
`define CL_OVM_BIT 19

// Modes and stop methods
`define MODE_SPEED 2'h0
`define MODE_POWER 2'h1
`define MODE_TORQUE 2'h2
`define MODE_VOLTAGE 2'h3
`define STOP_HIZ 2'h0
`define STOP_SPIN_DOWN 2'h1
`define STOP_BRAKE 2'h2
`define STOP_RESERVED 2'h3

// Sampling rate ceilings in kHz
`define FOC_RATE_HIGH_KHZ 4'hA
`define FOC_RATE_LOW_KHZ 4'h5

// Shares are in tenths of a percent
`define SHARE_W 10
`define SHARE_FULL_SCALE 10'h3E8
`define ZERO_HZ 1'b0

`endif

/* File: hw/share_scaler.v */
// Scales an absolute maximum by a share given in tenths of a percent
`timescale 1ns/1ps
`default_nettype none
`include "foc_cfg_consts.vh"

module share_scaler #(
    parameter VAL_W = 16
) (
    input wire clock_i,
    input wire srst_i,
    input wire [VAL_W-1:0] value_i,
    input wire [`SHARE_W-1:0] share_i,
    output reg [VAL_W-1:0] scaled_o
);
    localparam PROD_W = VAL_W + `SHARE_W;

    wire [PROD_W-1:0] product;
    wire [PROD_W-1:0] full_scale;
    wire [PROD_W-1:0] quotient;

    assign product = {{`SHARE_W{1'b0}}, value_i} * {{VAL_W{1'b0}}, share_i};
    assign full_scale = {{VAL_W{1'b0}}, `SHARE_FULL_SCALE};
    assign quotient = product / full_scale;

    always @(posedge clock_i) begin
        if (srst_i) begin
            scaled_o <= {VAL_W{1'b0}};
        end else begin
            scaled_o <= quotient[VAL_W-1:0];
        end
    end
endmodule // share_scaler

`default_nettype wire

/* File: hw/code_hold.v */
// Holds the last valid code of a field that has one reserved code
`timescale 1ns/1ps
`default_nettype none

module code_hold #(
    parameter W = 2,
    parameter [W-1:0] RESERVED = {W{1'b1}},
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input wire clock_i,
    input wire srst_i,
    input wire [W-1:0] code_i,
    output reg [W-1:0] held_o
);
    always @(posedge clock_i) begin
        if (srst_i) begin
            held_o <= RST;
        end else if (code_i != RESERVED) begin
            held_o <= code_i;
        end
    end
endmodule // code_hold

`default_nettype wire

/* File: hw/foc_startup_loop_config.v */
// Startup and closed-loop configuration registers with decoded settings
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "foc_cfg_consts.vh"

module foc_startup_loop_config #(
    parameter SPEED_W = 16,
    parameter CURRENT_W = 16
) (
    input wire clock_i,
    input wire srst_i,
    // Register port
    input wire [`CFG_ADDR_W-1:0] addr_i,
    input wire [`CFG_DATA_W-1:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [`CFG_DATA_W-1:0] rdata_o,
    // Scaling references
    input wire [SPEED_W-1:0] max_speed_i,
    input wire [CURRENT_W-1:0] base_current_i,
    // Startup settings
    output reg [`SHARE_W-1:0] initial_cycle_speed_share_o,
    output wire [SPEED_W-1:0] closed_first_freq_o,
    output reg [SPEED_W-1:0] open_first_freq_o,
    output reg initial_cycle_source_select_o,
    output reg [7:0] theta_ramp_rate_o,
    // Closed-loop settings
    output reg [1:0] control_mode_o,
    output reg mode_speed_o,
    output reg mode_power_o,
    output reg mode_torque_o,
    output reg mode_voltage_o,
    output reg fast_sampling_option_o,
    output reg [3:0] max_foc_rate_khz_o,
    output reg [`SHARE_W-1:0] current_ceiling_share_o,
    output wire [CURRENT_W-1:0] current_ceiling_o,
    output reg current_ceiling_active_o,
    output wire [1:0] stop_method_o,
    output reg overmod_en_o
);
    // ****************************************
    // Register storage
    // ****************************************
    reg [`CFG_DATA_W-1:0] startup_config_two;
    reg [`CFG_DATA_W-1:0] closed_loop_config;
    reg [`CFG_DATA_W-1:0] next_rdata;
    reg [`SHARE_W-1:0] next_speed_share;
    reg [`SHARE_W-1:0] next_current_share;
    reg [7:0] next_theta_rate;

    wire [3:0] speed_share_code;
    wire [2:0] theta_code;
    wire [4:0] ceiling_code;
    wire [1:0] mode_code;
    wire [1:0] stop_code;
    wire [SPEED_W-1:0] scaled_speed;

    assign speed_share_code = startup_config_two[`SCS_MSB:`SCS_LSB];
    assign theta_code = startup_config_two[`TER_MSB:`TER_LSB];
    assign mode_code = closed_loop_config[`CL_MODE_MSB:`CL_MODE_LSB];
    assign ceiling_code = closed_loop_config[`CL_ILIM_MSB:`CL_ILIM_LSB];
    assign stop_code = closed_loop_config[`CL_STOP_MSB:`CL_STOP_LSB];

    always @(posedge clock_i) begin
        if (srst_i) begin
            startup_config_two <= `STARTUP_CONFIG_TWO_RST;
            closed_loop_config <= `CLOSED_LOOP_CONFIG_RST;
        end else if (wr_i) begin
            if (addr_i == `STARTUP_CONFIG_TWO_ADDR) begin
                startup_config_two <= wdata_i;
            end
            if (addr_i == `CLOSED_LOOP_CONFIG_ADDR) begin
                // Whole word kept, reserved top bits included
                closed_loop_config <= wdata_i;
            end
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always @* begin
        next_rdata = `CFG_READ_ZERO;
        case (addr_i)
            `STARTUP_CONFIG_TWO_ADDR: begin
                next_rdata = startup_config_two;
            end
            `CLOSED_LOOP_CONFIG_ADDR: begin
                next_rdata = closed_loop_config;
            end
            `LOOP_STATUS_ADDR: begin
                next_rdata = {24'h000000, current_ceiling_active_o, overmod_en_o,
                    fast_sampling_option_o, initial_cycle_source_select_o,
                    stop_method_o, control_mode_o};
            end
            default: begin
                next_rdata = `CFG_READ_ZERO;
            end
        endcase
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            rdata_o <= `CFG_READ_ZERO;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= `CFG_READ_ZERO;
        end
    end

    // ****************************************
    // Startup share table, tenths of a percent
    // ****************************************
    always @* begin
        case (speed_share_code)
            4'h0: next_speed_share = 10'h00A;
            4'h1: next_speed_share = 10'h014;
            4'h2: next_speed_share = 10'h01E;
            4'h3: next_speed_share = 10'h032;
            4'h4: next_speed_share = 10'h04B;
            4'h5: next_speed_share = 10'h064;
            4'h6: next_speed_share = 10'h07D;
            4'h7: next_speed_share = 10'h096;
            4'h8: next_speed_share = 10'h0AF;
            4'h9: next_speed_share = 10'h0C8;
            4'hA: next_speed_share = 10'h0FA;
            4'hB: next_speed_share = 10'h12C;
            4'hC: next_speed_share = 10'h15E;
            4'hD: next_speed_share = 10'h190;
            4'hE: next_speed_share = 10'h1C2;
            default: next_speed_share = 10'h1F4;
        endcase
    end

    // ****************************************
    // Theta error ramp, hundredths of deg/ms
    // ****************************************
    always @* begin
        case (theta_code)
            3'h0: next_theta_rate = 8'h01;
            3'h1: next_theta_rate = 8'h05;
            3'h2: next_theta_rate = 8'h0A;
            3'h3: next_theta_rate = 8'h0F;
            3'h4: next_theta_rate = 8'h14;
            3'h5: next_theta_rate = 8'h32;
            3'h6: next_theta_rate = 8'h64;
            default: next_theta_rate = 8'hC8;
        endcase
    end

    // ****************************************
    // Current ceiling table, tenths of a percent
    // ****************************************
    always @* begin
        case (ceiling_code)
            5'h00: next_current_share = 10'h04B;
            5'h01: next_current_share = 10'h050;
            5'h02: next_current_share = 10'h055;
            5'h03: next_current_share = 10'h05A;
            5'h04: next_current_share = 10'h05F;
            5'h05: next_current_share = 10'h064;
            5'h06: next_current_share = 10'h06E;
            5'h07: next_current_share = 10'h078;
            5'h08: next_current_share = 10'h082;
            5'h09: next_current_share = 10'h08C;
            5'h0A: next_current_share = 10'h096;
            5'h0B: next_current_share = 10'h0A0;
            5'h0C: next_current_share = 10'h0AA;
            5'h0D: next_current_share = 10'h0B4;
            5'h0E: next_current_share = 10'h0C8;
            5'h0F: next_current_share = 10'h0E1;
            5'h10: next_current_share = 10'h0FA;
            5'h11: next_current_share = 10'h113;
            5'h12: next_current_share = 10'h12C;
            5'h13: next_current_share = 10'h15E;
            5'h14: next_current_share = 10'h190;
            5'h15: next_current_share = 10'h1C2;
            5'h16: next_current_share = 10'h1F4;
            5'h17: next_current_share = 10'h226;
            5'h18: next_current_share = 10'h258;
            5'h19: next_current_share = 10'h2BC;
            5'h1A: next_current_share = 10'h2EE;
            5'h1B: next_current_share = 10'h320;
            5'h1C: next_current_share = 10'h352;
            5'h1D: next_current_share = 10'h384;
            5'h1E: next_current_share = 10'h3B6;
            default: next_current_share = 10'h3E8;
        endcase
    end

    // ****************************************
    // Registered decoded settings
    // ****************************************
    always @(posedge clock_i) begin
        if (srst_i) begin
            initial_cycle_speed_share_o <= {`SHARE_W{1'b0}};
            initial_cycle_source_select_o <= 1'b0;
            theta_ramp_rate_o <= 8'h00;
            control_mode_o <= `MODE_SPEED;
            mode_speed_o <= 1'b0;
            mode_power_o <= 1'b0;
            mode_torque_o <= 1'b0;
            mode_voltage_o <= 1'b0;
            fast_sampling_option_o <= 1'b0;
            max_foc_rate_khz_o <= 4'h0;
            current_ceiling_share_o <= {`SHARE_W{1'b0}};
            current_ceiling_active_o <= 1'b0;
            overmod_en_o <= 1'b0;
        end else begin
            initial_cycle_speed_share_o <= next_speed_share;
            initial_cycle_source_select_o <= startup_config_two[`ICS_SEL_BIT];
            theta_ramp_rate_o <= next_theta_rate;
            control_mode_o <= mode_code;
            mode_speed_o <= (mode_code == `MODE_SPEED);
            mode_power_o <= (mode_code == `MODE_POWER);
            mode_torque_o <= (mode_code == `MODE_TORQUE);
            mode_voltage_o <= (mode_code == `MODE_VOLTAGE);
            // Bit clear means the high rate is enabled
            fast_sampling_option_o <= ~closed_loop_config[`CL_FAST_BIT];
            if (closed_loop_config[`CL_FAST_BIT]) begin
                max_foc_rate_khz_o <= `FOC_RATE_LOW_KHZ;
            end else begin
                max_foc_rate_khz_o <= `FOC_RATE_HIGH_KHZ;
            end
            current_ceiling_share_o <= next_current_share;
            // Ceiling applies only in torque and speed modes
            current_ceiling_active_o <= (mode_code == `MODE_TORQUE) ||
                (mode_code == `MODE_SPEED);
            overmod_en_o <= closed_loop_config[`CL_OVM_BIT];
        end
    end

    // ****************************************
    // Absolute values from shares
    // ****************************************
    share_scaler #(
        .VAL_W(SPEED_W)
    ) u_speed_scaler (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .value_i(max_speed_i),
        .share_i(initial_cycle_speed_share_o),
        .scaled_o(scaled_speed)
    );

    share_scaler #(
        .VAL_W(CURRENT_W)
    ) u_current_scaler (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .value_i(base_current_i),
        .share_i(current_ceiling_share_o),
        .scaled_o(current_ceiling_o)
    );

    assign closed_first_freq_o = scaled_speed;

    always @(posedge clock_i) begin
        if (srst_i) begin
            open_first_freq_o <= {SPEED_W{1'b0}};
        end else if (initial_cycle_source_select_o) begin
            open_first_freq_o <= {SPEED_W{`ZERO_HZ}};
        end else begin
            open_first_freq_o <= scaled_speed;
        end
    end

    // ****************************************
    // Stop method with reserved code filtered
    // ****************************************
    code_hold #(
        .W(2),
        .RESERVED(`STOP_RESERVED),
        .RST(`STOP_HIZ)
    ) u_stop_hold (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .code_i(stop_code),
        .held_o(stop_method_o)
    );

endmodule // foc_startup_loop_config

`default_nettype wire

/* File: dv/motor_stage_model.sv */
// Model of the motor and power stage that supplies speed and current ratings
`timescale 1ns/1ps
`default_nettype none

module motor_stage_model (
    input wire logic clock_i,
    input wire logic load_i,
    input wire logic [31:0] rating_i,
    output logic [15:0] max_speed_o,
    output logic [15:0] base_current_o
);
    // Ratings are fixed by the motor and only change on a new load
    always @(posedge clock_i) begin
        if (load_i) begin
            max_speed_o <= rating_i[31:16];
            base_current_o <= rating_i[15:0];
        end
    end
endmodule // motor_stage_model

`default_nettype wire

/* File: dv/foc_cfg_chk.sv */
// Assertions on the ports of the configuration decoder
`timescale 1ns/1ps
`default_nettype none

module foc_cfg_chk #(
    parameter SPEED_W = 16,
    parameter CURRENT_W = 16
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [CURRENT_W-1:0] base_current_i,
    input wire logic [SPEED_W-1:0] open_first_freq_o,
    input wire logic initial_cycle_source_select_o,
    input wire logic [1:0] control_mode_o,
    input wire logic mode_speed_o,
    input wire logic mode_power_o,
    input wire logic mode_torque_o,
    input wire logic mode_voltage_o,
    input wire logic fast_sampling_option_o,
    input wire logic [9:0] current_ceiling_share_o,
    input wire logic [CURRENT_W-1:0] current_ceiling_o,
    input wire logic current_ceiling_active_o,
    input wire logic [1:0] stop_method_o,
    input wire logic overmod_en_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);

    sequence s_cl_wr;
        wr_i && addr_i == 8'h48;
    endsequence
    sequence s_quiet;
        !$past(wr_i) && !$past(wr_i, 2);
    endsequence

    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data not idle");
    AST_MODE_HOT: assert property (!$past(srst_i) |->
        {mode_voltage_o, mode_torque_o, mode_power_o, mode_speed_o} == 4'h1 << control_mode_o)
        else $error("mode flags disagree with mode");
    AST_CEIL_ACT: assert property (!$past(srst_i) |->
        current_ceiling_active_o == (control_mode_o == 2'h0 || control_mode_o == 2'h2))
        else $error("ceiling active in wrong mode");
    AST_STOP_VALID: assert property (stop_method_o != 2'h3)
        else $error("reserved stop method driven");
    AST_CL_WRITE: assert property (s_cl_wr |-> ##3 (control_mode_o == $past(wdata_i[29:28], 3)
        && overmod_en_o == $past(wdata_i[19], 3) && fast_sampling_option_o == !$past(wdata_i[27], 3)))
        else $error("loop settings not taken from write");
    AST_STOP_SET: assert property (s_cl_wr ##0 wdata_i[21:20] != 2'h3 |->
        ##3 stop_method_o == $past(wdata_i[21:20], 3))
        else $error("stop method not taken from write");
    AST_STOP_KEEP: assert property (s_cl_wr ##0 wdata_i[21:20] == 2'h3 ##0 s_quiet |->
        ##3 stop_method_o == $past(stop_method_o, 3))
        else $error("reserved stop code changed method");
    AST_OPEN_ZERO: assert property (initial_cycle_source_select_o [*4] |->
        open_first_freq_o == 0)
        else $error("open first frequency not zero");
    AST_CEIL_SCALE: assert property (!$past(srst_i) && $stable(base_current_i)
        && $stable(current_ceiling_share_o) |=> current_ceiling_o ==
        CURRENT_W'(32'($past(base_current_i)) * $past(current_ceiling_share_o) / 1000))
        else $error("current ceiling scaling wrong");
endmodule // foc_cfg_chk

bind foc_startup_loop_config foc_cfg_chk #(
    .SPEED_W(SPEED_W),
    .CURRENT_W(CURRENT_W)
) chk_i (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .base_current_i(base_current_i),
    .open_first_freq_o(open_first_freq_o),
    .initial_cycle_source_select_o(initial_cycle_source_select_o),
    .control_mode_o(control_mode_o),
    .mode_speed_o(mode_speed_o),
    .mode_power_o(mode_power_o),
    .mode_torque_o(mode_torque_o),
    .mode_voltage_o(mode_voltage_o),
    .fast_sampling_option_o(fast_sampling_option_o),
    .current_ceiling_share_o(current_ceiling_share_o),
    .current_ceiling_o(current_ceiling_o),
    .current_ceiling_active_o(current_ceiling_active_o),
    .stop_method_o(stop_method_o),
    .overmod_en_o(overmod_en_o)
);

`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the configuration decoder
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clock_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, load = 1;
    logic [7:0] addr_i = 0;
    logic [31:0] wdata_i = 0, rating = 0, rdata_o, got, st_m = 0, cl_m = 0;
    logic [15:0] max_speed_i, base_current_i, closed_first_freq_o, open_first_freq_o;
    logic [15:0] current_ceiling_o;
    logic [9:0] initial_cycle_speed_share_o, current_ceiling_share_o;
    logic [7:0] theta_ramp_rate_o;
    logic [3:0] max_foc_rate_khz_o;
    logic [1:0] control_mode_o, stop_method_o, stop_m = 0;
    logic initial_cycle_source_select_o, mode_speed_o, mode_power_o, mode_torque_o;
    logic mode_voltage_o, fast_sampling_option_o, current_ceiling_active_o, overmod_en_o;
    int n_fail = 0, num_checks = 0, i, sp, cu;
    int scs_t[16] = '{10, 20, 30, 50, 75, 100, 125, 150, 175, 200, 250, 300, 350, 400, 450, 500};
    int ter_t[8] = '{1, 5, 10, 15, 20, 50, 100, 200};
    int ilim_t[32] = '{75, 80, 85, 90, 95, 100, 110, 120, 130, 140, 150, 160, 170, 180, 200,
        225, 250, 275, 300, 350, 400, 450, 500, 550, 600, 700, 750, 800, 850, 900, 950, 1000};

    foc_startup_loop_config dut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .max_speed_i(max_speed_i), .base_current_i(base_current_i),
        .initial_cycle_speed_share_o(initial_cycle_speed_share_o),
        .closed_first_freq_o(closed_first_freq_o),
        .open_first_freq_o(open_first_freq_o),
        .initial_cycle_source_select_o(initial_cycle_source_select_o),
        .theta_ramp_rate_o(theta_ramp_rate_o), .control_mode_o(control_mode_o),
        .mode_speed_o(mode_speed_o), .mode_power_o(mode_power_o),
        .mode_torque_o(mode_torque_o), .mode_voltage_o(mode_voltage_o),
        .fast_sampling_option_o(fast_sampling_option_o),
        .max_foc_rate_khz_o(max_foc_rate_khz_o),
        .current_ceiling_share_o(current_ceiling_share_o),
        .current_ceiling_o(current_ceiling_o),
        .current_ceiling_active_o(current_ceiling_active_o),
        .stop_method_o(stop_method_o), .overmod_en_o(overmod_en_o));
    motor_stage_model motor (.clock_i(clock_i), .load_i(load), .rating_i(rating),
        .max_speed_o(max_speed_i), .base_current_o(base_current_i));

    initial forever #4 clock_i = ~clock_i;

    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        wr_i <= 1; addr_i <= a; wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 0;
        #1;
    endtask
    task rd(input logic [7:0] a);
        rd_i <= 1; addr_i <= a;
        @(posedge clock_i);
        rd_i <= 0;
        #1 got = rdata_o;
    endtask
    task conclude;
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************
    // Model of decoded settings
    // ****************************************
    task outs;
        int md, ft, fr;
        logic [31:0] sv;
        md = cl_m[29:28];
        ft = cl_m[26:22];
        fr = sp * scs_t[st_m[7:4]] / 1000;
        chk(initial_cycle_speed_share_o, scs_t[st_m[7:4]]);
        chk(closed_first_freq_o, fr);
        chk(initial_cycle_source_select_o, st_m[3]);
        chk(open_first_freq_o, st_m[3] ? 0 : fr);
        chk(theta_ramp_rate_o, ter_t[st_m[2:0]]);
        chk(control_mode_o, md);
        chk({mode_voltage_o, mode_torque_o, mode_power_o, mode_speed_o}, 1 << md);
        chk(fast_sampling_option_o, !cl_m[27]);
        chk(max_foc_rate_khz_o, cl_m[27] ? 5 : 10);
        chk(current_ceiling_share_o, ilim_t[ft]);
        chk(current_ceiling_o, cu * ilim_t[ft] / 1000);
        chk(current_ceiling_active_o, md == 0 || md == 2);
        chk(stop_method_o, stop_m);
        chk(overmod_en_o, cl_m[19]);
        rd(8'h4C);
        sv = {24'h0, md == 0 || md == 2, cl_m[19], !cl_m[27], st_m[3], stop_m, cl_m[29:28]};
        chk(got, sv);
    endtask

    initial begin
        i = $urandom(65);
        repeat (5) @(posedge clock_i);
        srst_i <= 0;
        load <= 0;
        @(posedge clock_i);
        rd(8'h48);
        chk(got, 0);
        for (i = 0; i < 32; i++) begin
            sp = $urandom_range(65535);
            cu = $urandom_range(65535);
            rating <= {16'(sp), 16'(cu)};
            load <= 1;
            @(posedge clock_i);
            load <= 0;
            cl_m = $urandom;
            cl_m[26:22] = 5'(i);
            cl_m[29:28] = 2'(i >> 1);
            cl_m[21:20] = 2'(i);
            if (cl_m[21:20] != 2'h3)
                stop_m = cl_m[21:20];
            st_m = $urandom;
            wr(8'h48, cl_m);
            rd(8'h48);
            chk(got, cl_m);
            wr(8'h44, st_m);
            wr(8'h4C, ~st_m);
            wr(8'h60, st_m);
            rd(8'h44);
            chk(got, st_m);
            rd(8'h60);
            chk(got, 0);
            repeat (5) @(posedge clock_i);
            #1 outs;
        end
        srst_i <= 1;
        repeat (2) @(posedge clock_i);
        srst_i <= 0;
        @(posedge clock_i);
        rd(8'h48);
        chk(got, 0);
        cl_m = 0;
        st_m = 0;
        stop_m = 0;
        repeat (4) @(posedge clock_i);
        #1 outs;
        conclude;
    end

    initial begin
        #(8 * 5000);
        n_fail++;
        conclude;
    end
endmodule // testbench

`default_nettype wire
